/* hw/tec_pkg.sv */
// package for the 8-bit timer/event counter: register map, fields, resets
// assumes an avalon-mm master with byte addresses and 32-bit data
package tec_pkg;
    // ***********************************************************
    // register indices; byte address is four times the index
    // ***********************************************************
    localparam logic [5:0] IDX_COUNT   = 6'h0d;
    localparam logic [5:0] IDX_CONTROL = 6'h0e;
    localparam logic [5:0] IDX_INTCTRL = 6'h10;
    localparam logic [5:0] IDX_BUZZER  = 6'h11;

    // ***********************************************************
    // timer_control fields
    // ***********************************************************
    localparam int PSC_LSB       = 0;
    localparam int PSC_MSB       = 2;
    localparam int EDGE_BIT      = 3;
    localparam int ENABLE_BIT    = 4;
    localparam int UNUSED_BIT    = 5;
    localparam int MODE_LSB      = 6;
    localparam int MODE_MSB      = 7;
    localparam logic [7:0] CONTROL_RESET = 8'h08;
    localparam logic [7:0] COUNT_RESET   = 8'h00;
    localparam logic [7:0] COUNT_TOP     = 8'hff;

    // ***********************************************************
    // interrupt_control and buzzer/port fields
    // ***********************************************************
    localparam int IRQ_EN_BIT    = 0;
    localparam int OVF_FLAG_BIT  = 5;
    localparam int BZ_OPT_BIT    = 0;
    localparam int PIN0_DIR_BIT  = 1;
    localparam int PIN1_DIR_BIT  = 2;
    localparam int PIN0_DATA_BIT = 3;
    localparam int PIN1_DATA_BIT = 4;

    // ***********************************************************
    // modes and states
    // ***********************************************************
    typedef enum logic [1:0] {
        TEC_MODE_UNUSED = 2'h0,
        TEC_MODE_EVENT  = 2'h1,
        TEC_MODE_TIMER  = 2'h2,
        TEC_MODE_PULSE  = 2'h3
    } tec_mode_t;

    typedef enum logic {
        TEC_PW_IDLE,
        TEC_PW_MEASURE
    } tec_pw_t;
endpackage

/* hw/tec_timer_event_counter.sv */
// 8-bit timer/event counter with preload, prescaler, pulse-width mode,
// overflow flag, wake pulse and buzzer divider output.
// assumes: one 100 mhz clock, synchronous active-low cold reset, timer pin
// already synchronous to clk, avalon-mm slave with byte addressing.
//
// The Avalon-MM interface to the registers was left to the implementer.
`timescale 1ns/1ns

// Overview of operation
// [RQ1] eight-bit up-counter clocked from timer pin or prescaled system clock
// [RQ2] data address: writes go to preload, reads return live count
// [RQ3] control bits 7:6 choose event, timer, pulse-width or unused mode
// [RQ4] control bits 2:0 divide system clock by two to the field plus one
// [RQ5] event and timer modes count from present value up to ff
// [RQ6] overflow reloads from preload and sets flag bit 5 same cycle
// [RQ7] control bit 3 picks pin edge: 0 rising, 1 falling
// [RQ8] control bit 4 enables counting; must be set before counting
// [RQ9] pulse mode: active edge starts, return edge stops and clears enable
// [RQ10] one measurement result held until software sets enable again
// [RQ11] pulse mode starts on an edge, never on a level
// [RQ12] overflow in pulse mode reloads and raises request like other modes
// [RQ13] event and timer modes: only software clears enable
// [RQ14] overflow is a wake-up source ending halt
// [RQ15] cleared interrupt enable blocks overflow servicing in every mode
// [RQ16] data write while disabled loads preload and counter
// [RQ17] data write while enabled loads only preload, counter runs on
// [RQ18] count clock is blocked while the counter is read
// [RQ19] control bit 5 unimplemented, reads zero
// [RQ20] divider output frequency is f_int over twice 256 minus preload
// [RQ21] cold reset sets control to 08; warm reset keeps both registers
// [RQ22] event mode clocked by pin; timer and pulse by prescaled clock
// [RQ23] buzzer option drives divider on output pins, gated by pin-0 latch
// [RQ24] divider output toggles on every overflow
module tec_timer_event_counter (
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic [7:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic        timerCountPin,
    output logic             overflowIrqReq,
    output logic             haltWake,
    output logic             freqDividerOut,
    output logic             buzzPin0Out,
    output logic             buzzPin0Oe,
    output logic             buzzPin1Out,
    output logic             buzzPin1Oe
);
    // ***********************************************************
    // avalon slave: one wait cycle per access
    // ***********************************************************
    logic        ack_r;
    logic [31:0] rdData_r;
    logic        busReq;
    logic        accept;
    logic        wrFire;
    logic [5:0]  regIdx;
    logic        wrCount;
    logic        wrControl;
    logic        wrIntCtrl;
    logic        wrBuzzer;

    assign busReq          = avs_read | avs_write;
    assign avs_waitrequest = busReq & ~ack_r;
    assign accept          = busReq & ack_r;
    assign wrFire          = accept & avs_write & avs_byteenable[0];
    assign regIdx          = avs_address[7:2];
    assign wrCount         = wrFire && regIdx == tec_pkg::IDX_COUNT;
    assign wrControl       = wrFire && regIdx == tec_pkg::IDX_CONTROL;
    assign wrIntCtrl       = wrFire && regIdx == tec_pkg::IDX_INTCTRL;
    assign wrBuzzer        = wrFire && regIdx == tec_pkg::IDX_BUZZER;
    assign avs_readdata    = rdData_r;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= busReq & ~ack_r;
        end
    end

    // ***********************************************************
    // registers
    // ***********************************************************
    logic [7:0] preload_r;
    logic [7:0] count_r;
    logic [7:0] control_r;
    logic       ovfFlag_r;
    logic       irqEn_r;
    logic [4:0] buzzer_r;
    logic [7:0] prescale_r;
    logic       pinPrev_r;
    logic       tone_r;
    logic       wake_r;
    tec_pkg::tec_pw_t pwState_r;

    logic [2:0] pscSel;
    logic [7:0] pscMask;
    logic       fintTick;
    logic       enable;
    logic       activeEdge;
    logic       returnEdge;
    logic       readGate;
    logic       countTick;
    logic       overflow;
    logic       pwStop;
    tec_pkg::tec_mode_t mode;

    assign mode   = tec_pkg::tec_mode_t'(
                    control_r[tec_pkg::MODE_MSB:tec_pkg::MODE_LSB]);
    assign enable = control_r[tec_pkg::ENABLE_BIT];
    assign pscSel = control_r[tec_pkg::PSC_MSB:tec_pkg::PSC_LSB];

    // ***********************************************************
    // prescaler and pin edges
    // ***********************************************************
    // f_int tick when the low psc+1 prescaler bits are all ones
    assign pscMask  = 8'hff >> (3'h7 - pscSel); // [RQ4]
    assign fintTick = &(prescale_r | ~pscMask); // [RQ4]

    always_ff @(posedge clk) begin
        if (!resetn) begin
            prescale_r <= 8'h00;
        end else begin
            prescale_r <= prescale_r + 8'h01;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            pinPrev_r <= 1'b0;
        end else begin
            pinPrev_r <= timerCountPin;
        end
    end

    // edge select: 0 rising, 1 falling
    assign activeEdge = control_r[tec_pkg::EDGE_BIT] ?
                        (pinPrev_r & ~timerCountPin) :
                        (~pinPrev_r & timerCountPin); // [RQ7]
    assign returnEdge = control_r[tec_pkg::EDGE_BIT] ?
                        (~pinPrev_r & timerCountPin) :
                        (pinPrev_r & ~timerCountPin); // [RQ9]

    // ***********************************************************
    // count clock selection
    // ***********************************************************
    // counts lost during a read are accepted for a coherent value
    assign readGate = avs_read &&
                      regIdx == tec_pkg::IDX_COUNT; // [RQ18]

    always_comb begin
        countTick = 1'b0;
        unique case (mode)
            tec_pkg::TEC_MODE_EVENT:  countTick = activeEdge; // [RQ22]
            tec_pkg::TEC_MODE_TIMER:  countTick = fintTick;   // [RQ22]
            tec_pkg::TEC_MODE_PULSE:
                countTick = fintTick &&
                            pwState_r == tec_pkg::TEC_PW_MEASURE; // [RQ9]
            tec_pkg::TEC_MODE_UNUSED: countTick = 1'b0;        // [RQ3]
        endcase
        countTick = countTick & enable & ~readGate; // [RQ8] [RQ18]
    end

    assign overflow = countTick && count_r == tec_pkg::COUNT_TOP; // [RQ5]

    // ***********************************************************
    // pulse-width measurement
    // ***********************************************************
    assign pwStop = mode == tec_pkg::TEC_MODE_PULSE &&
                    pwState_r == tec_pkg::TEC_PW_MEASURE && returnEdge;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            pwState_r <= tec_pkg::TEC_PW_IDLE;
        end else if (mode != tec_pkg::TEC_MODE_PULSE || !enable) begin
            pwState_r <= tec_pkg::TEC_PW_IDLE;
        end else begin
            unique case (pwState_r)
                tec_pkg::TEC_PW_IDLE: begin
                    if (activeEdge) begin
                        pwState_r <= tec_pkg::TEC_PW_MEASURE; // [RQ11]
                    end
                end
                tec_pkg::TEC_PW_MEASURE: begin
                    if (returnEdge) begin
                        pwState_r <= tec_pkg::TEC_PW_IDLE; // [RQ9]
                    end
                end
            endcase
        end
    end

    // ***********************************************************
    // control register
    // ***********************************************************
    // software write wins over the hardware stop so a re-arm is not lost
    always_ff @(posedge clk) begin
        if (!resetn) begin
            control_r <= tec_pkg::CONTROL_RESET; // [RQ21]
        end else if (wrControl) begin
            control_r <= avs_writedata[7:0] &
                         ~(8'h01 << tec_pkg::UNUSED_BIT); // [RQ19]
        end else if (pwStop) begin
            control_r[tec_pkg::ENABLE_BIT] <= 1'b0; // [RQ9] [RQ10] [RQ13]
        end
    end

    // ***********************************************************
    // preload and counter
    // ***********************************************************
    always_ff @(posedge clk) begin
        if (!resetn) begin
            preload_r <= tec_pkg::COUNT_RESET;
        end else if (wrCount) begin
            preload_r <= avs_writedata[7:0]; // [RQ2] [RQ17]
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            count_r <= tec_pkg::COUNT_RESET;
        end else if (wrCount && !enable) begin
            count_r <= avs_writedata[7:0]; // [RQ16]
        end else if (overflow) begin
            count_r <= preload_r; // [RQ6] [RQ12]
        end else if (countTick) begin
            count_r <= count_r + 8'h01; // [RQ1] [RQ5]
        end
    end

    // ***********************************************************
    // overflow flag, interrupt enable, wake, divider
    // ***********************************************************
    // set wins over a software clear in the same cycle
    always_ff @(posedge clk) begin
        if (!resetn) begin
            ovfFlag_r <= 1'b0;
        end else if (overflow) begin
            ovfFlag_r <= 1'b1; // [RQ6] [RQ12]
        end else if (wrIntCtrl) begin
            ovfFlag_r <= avs_writedata[tec_pkg::OVF_FLAG_BIT];
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            irqEn_r <= 1'b0;
        end else if (wrIntCtrl) begin
            irqEn_r <= avs_writedata[tec_pkg::IRQ_EN_BIT];
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            overflowIrqReq <= 1'b0;
        end else begin
            overflowIrqReq <= ovfFlag_r & irqEn_r; // [RQ15]
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            wake_r <= 1'b0;
        end else begin
            wake_r <= overflow; // [RQ14]
        end
    end
    assign haltWake = wake_r;

    // one toggle per overflow gives f_int / (2 * (256 - preload))
    always_ff @(posedge clk) begin
        if (!resetn) begin
            tone_r <= 1'b0;
        end else if (overflow) begin
            tone_r <= ~tone_r; // [RQ20] [RQ24]
        end
    end
    assign freqDividerOut = tone_r;

    // ***********************************************************
    // buzzer pins
    // ***********************************************************
    always_ff @(posedge clk) begin
        if (!resetn) begin
            buzzer_r <= 5'h00;
        end else if (wrBuzzer) begin
            buzzer_r <= avs_writedata[4:0];
        end
    end

    // with the buzzer option and pin-0 latch set, pin 1 carries the inverse of pin 0 for a push-pull buzzer pair
    always_ff @(posedge clk) begin
        if (!resetn) begin
            buzzPin0Out <= 1'b0;
            buzzPin1Out <= 1'b0;
        end else if (buzzer_r[tec_pkg::BZ_OPT_BIT]) begin
            buzzPin0Out <= tone_r & buzzer_r[tec_pkg::PIN0_DATA_BIT]; // [RQ23]
            buzzPin1Out <= ~tone_r & buzzer_r[tec_pkg::PIN0_DATA_BIT];
        end else begin
            buzzPin0Out <= buzzer_r[tec_pkg::PIN0_DATA_BIT];
            buzzPin1Out <= buzzer_r[tec_pkg::PIN1_DATA_BIT];
        end
    end
    assign buzzPin0Oe = buzzer_r[tec_pkg::PIN0_DIR_BIT];
    assign buzzPin1Oe = buzzer_r[tec_pkg::PIN1_DIR_BIT];

    // ***********************************************************
    // read data
    // ***********************************************************
    always_ff @(posedge clk) begin
        if (!resetn) begin
            rdData_r <= 32'h0000_0000;
        end else if (avs_read && !ack_r) begin
            rdData_r <= 32'h0000_0000;
            unique case (regIdx)
                tec_pkg::IDX_COUNT:   rdData_r[7:0] <= count_r; // [RQ2]
                tec_pkg::IDX_CONTROL: rdData_r[7:0] <= control_r;
                tec_pkg::IDX_INTCTRL: begin
                    rdData_r[tec_pkg::OVF_FLAG_BIT] <= ovfFlag_r;
                    rdData_r[tec_pkg::IRQ_EN_BIT]   <= irqEn_r;
                end
                tec_pkg::IDX_BUZZER:  rdData_r[4:0] <= buzzer_r;
                default:              rdData_r <= 32'h0000_0000;
            endcase
        end
    end

    // ***********************************************************
    // assertions
    // ***********************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    sequence ovfSeq;
        overflow;
    endsequence

    sequence armStartSeq;
        mode == tec_pkg::TEC_MODE_PULSE && enable && !wrControl &&
        pwState_r == tec_pkg::TEC_PW_IDLE && activeEdge;
    endsequence

    sequence stopSeq;
        pwStop && !wrControl;
    endsequence

    ovf_reload_a: assert property (ovfSeq |=> // [RQ6]
        count_r == $past(preload_r))
        else $error("counter not reloaded on overflow");
    ovf_flag_a: assert property (ovfSeq |=> ovfFlag_r) // [RQ6] [RQ12]
        else $error("overflow flag not set");
    ctrl_bit5_a: assert property (accept && avs_read && // [RQ19]
        regIdx == tec_pkg::IDX_CONTROL |-> avs_readdata[5] == 1'b0)
        else $error("control bit 5 read nonzero");
    pw_start_a: assert property (armStartSeq |=> // [RQ11]
        pwState_r == tec_pkg::TEC_PW_MEASURE)
        else $error("pulse measurement did not start on edge");
    pw_stop_a: assert property (stopSeq |=> !enable ##1 // [RQ9]
        (enable || pwState_r == tec_pkg::TEC_PW_IDLE))
        else $error("enable not cleared after pulse");
    en_keep_a: assert property (enable && !wrControl && // [RQ13]
        mode != tec_pkg::TEC_MODE_PULSE |=> enable)
        else $error("hardware cleared enable outside pulse mode");
    wr_off_a: assert property (wrCount && !enable |=> // [RQ16]
        count_r == $past(avs_writedata[7:0]) &&
        preload_r == $past(avs_writedata[7:0]))
        else $error("disabled write did not load counter");
    wr_on_a: assert property (wrCount && enable && !overflow |=> // [RQ17]
        count_r == $past(count_r) + {7'h00, $past(countTick)})
        else $error("enabled write disturbed counter");
    read_gate_a: assert property (readGate |=> $stable(count_r)) // [RQ18]
        else $error("counter moved during read");
    div_toggle_a: assert property (ovfSeq |=> // [RQ24]
        freqDividerOut != $past(freqDividerOut))
        else $error("divider did not toggle");
    irq_gate_a: assert property (!irqEn_r |=> !overflowIrqReq) // [RQ15]
        else $error("request passed with enable clear");
    wake_a: assert property (ovfSeq |=> haltWake) // [RQ14]
        else $error("no wake pulse on overflow");
endmodule

/* sim/tec_pin_source.sv */
// partner model: the external event and pulse source on the timer pin
// assumes the caller enters drive just after a rising edge of clk
`timescale 1ns/1ns
module tec_pin_source (
    input  wire logic clk,
    output logic      pinLevel
);
    initial pinLevel = 1'b0;

    // whole-cycle levels only, so each change is one clean edge
    task automatic drive(input logic lvl, input int hold);
        pinLevel <= lvl;
        repeat (hold) @(posedge clk);
    endtask
endmodule

/* sim/timer_event_counter_8bit_tb_top.sv */
// self-checking bench for the 8-bit timer/event counter
// assumes the avalon slave answers after one wait cycle, pin model beside it
`timescale 1ns/1ns
module timer_event_counter_8bit_tb_top;
    localparam logic [7:0] A_CNT = 8'h34;
    localparam logic [7:0] A_CTL = 8'h38;
    localparam logic [7:0] A_IRQ = 8'h40;
    localparam logic [7:0] A_BZ  = 8'h44;

    logic        clk          = 1'b0;
    logic        resetn       = 1'b0;
    logic [7:0]  avsAddress   = 8'h00;
    logic        avsRead      = 1'b0;
    logic        avsWrite     = 1'b0;
    logic [31:0] avsWritedata = 32'h00000000;
    logic [31:0] avsReaddata;
    logic        avsWaitrequest;
    logic        pinLevel;
    logic        overflowIrqReq;
    logic        haltWake;
    logic        freqDividerOut;
    logic        buzzPin0Out;
    logic        buzzPin0Oe;
    logic        buzzPin1Out;
    logic        buzzPin1Oe;
    logic        divPrev      = 1'b0;
    int          nDiv         = 0;
    int          nWake        = 0;
    int          cyc          = 0;
    int          n_fail       = 0;
    int          n_tests      = 0;

    always #5 clk = ~clk;

    tec_timer_event_counter tec_timer_event_counter_inst (
        .clk(clk), .resetn(resetn), .avs_address(avsAddress),
        .avs_read(avsRead), .avs_write(avsWrite),
        .avs_writedata(avsWritedata), .avs_byteenable(4'hf),
        .avs_readdata(avsReaddata), .avs_waitrequest(avsWaitrequest),
        .timerCountPin(pinLevel), .overflowIrqReq(overflowIrqReq),
        .haltWake(haltWake), .freqDividerOut(freqDividerOut),
        .buzzPin0Out(buzzPin0Out), .buzzPin0Oe(buzzPin0Oe),
        .buzzPin1Out(buzzPin1Out), .buzzPin1Oe(buzzPin1Oe)
    );

    tec_pin_source tec_pin_source_inst (
        .clk(clk),
        .pinLevel(pinLevel)
    );

    // ***********************************************************
    // reporting and watchdog
    // ***********************************************************
    task automatic conclude();
        if (n_fail == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // prescaler phase is free running, so one tick either way is allowed
    task automatic rng(input logic [7:0] q, input int e);
        chk((q >= 8'(e - 1) && q <= 8'(e + 1)) ? 8'(e) : q, 8'(e));
    endtask

    always @(posedge clk) begin
        divPrev <= freqDividerOut;
        if (resetn && freqDividerOut !== divPrev) nDiv <= nDiv + 1;
        if (resetn && haltWake === 1'b1) nWake <= nWake + 1;
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            n_fail++;
            conclude();
        end
    end

    // ***********************************************************
    // bus cycles
    // ***********************************************************
    task automatic bus(input logic wr, input logic [7:0] a,
                       input logic [7:0] d, output logic [7:0] q);
        avsAddress   <= a;
        avsWritedata <= {24'h000000, d};
        avsWrite     <= wr;
        avsRead      <= ~wr;
        do @(posedge clk); while (avsWaitrequest !== 1'b0);
        q = avsReaddata[7:0];
        avsWrite <= 1'b0;
        avsRead  <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] q);
        bus(1'b0, a, 8'h00, q);
    endtask

    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] q;
        rd(a, q);
        chk(q, e);
    endtask

    // counter after k events: wraps to the preload and counts overflows
    function automatic logic [7:0] adv(input logic [7:0] s,
                                       input logic [7:0] p,
                                       input int k, inout int ov);
        for (int j = 0; j < k; j++) begin
            if (s == 8'hff) begin
                s = p;
                ov++;
            end else begin
                s = s + 8'h01;
            end
        end
        return s;
    endfunction

    // ***********************************************************
    // main sequence
    // ***********************************************************
    initial begin
        logic [7:0] s, p, q, e;
        int         k, ov, len;
        ov = 0;
        void'($urandom(32'hdd54));
        repeat (5) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        rchk(A_CTL, 8'h08);
        wr(A_CTL, 8'h20);
        rchk(A_CTL, 8'h00);
        rchk(8'h00, 8'h00);
        // mode 00 holds the counter even with enable set
        wr(A_CNT, 8'h5a);
        wr(A_CTL, 8'h10);
        repeat (20) @(posedge clk);
        rchk(A_CNT, 8'h5a);
        // event counting on both edges, first runs forced over the top
        for (int i = 0; i < 6; i++) begin
            e = {4'h0, i[0], 3'h0};
            s = (i < 3) ? (8'hf8 | 8'($urandom % 8)) : 8'($urandom);
            p = 8'($urandom);
            k = (i < 3) ? 8 : 1 + $urandom % 8;
            wr(A_CTL, 8'h40 | e);
            tec_pin_source_inst.drive(i[0], 2);
            wr(A_CNT, s);
            wr(A_CTL, 8'h50 | e);
            wr(A_CNT, p);
            rchk(A_CNT, s);
            repeat (k) begin
                tec_pin_source_inst.drive(~i[0], 2);
                tec_pin_source_inst.drive(i[0], 2);
            end
            rchk(A_CTL, 8'h50 | e);
            rchk(A_CNT, adv(s, p, k, ov));
        end
        rd(A_IRQ, q);
        chk(q & 8'h21, 8'h20);
        chk({7'h00, overflowIrqReq}, 8'h00);
        chk(8'(nDiv), 8'(ov));
        chk(8'(nWake), 8'(ov));
        // interrupt enabled, buzzer routed to the pins
        wr(A_IRQ, 8'h01);
        wr(A_BZ, 8'h0f);
        wr(A_CTL, 8'h40);
        tec_pin_source_inst.drive(1'b0, 2);
        wr(A_CNT, 8'hff);
        wr(A_CTL, 8'h50);
        chk({7'h00, overflowIrqReq}, 8'h00);
        tec_pin_source_inst.drive(1'b1, 2);
        tec_pin_source_inst.drive(1'b0, 2);
        ov++;
        chk({7'h00, overflowIrqReq}, 8'h01);
        e = {6'h00, ~ov[0], ov[0]};
        chk({6'h00, buzzPin1Out, buzzPin0Out}, e);
        chk({6'h00, buzzPin1Oe, buzzPin0Oe}, 8'h03);
        rchk(A_CNT, 8'hff);
        wr(A_IRQ, 8'h00);
        // request register trails the enable by one cycle
        @(posedge clk);
        chk({7'h00, overflowIrqReq}, 8'h00);
        wr(A_BZ, 8'h07);
        repeat (2) @(posedge clk);
        chk({6'h00, buzzPin1Out, buzzPin0Out}, 8'h00);
        // timer mode across every prescaler setting, four ticks each
        for (int ps = 0; ps < 8; ps++) begin
            wr(A_CTL, 8'h80 | 8'(ps));
            wr(A_CNT, 8'h00);
            wr(A_CTL, 8'h90 | 8'(ps));
            repeat ((8 << ps) - 3) @(posedge clk);
            wr(A_CTL, 8'h80 | 8'(ps));
            rd(A_CNT, q);
            chk(q, 8'h04);
        end
        // pulse width: armed at the active level, then one real pulse
        wr(A_CTL, 8'hc0);
        wr(A_CNT, 8'h00);
        tec_pin_source_inst.drive(1'b1, 2);
        wr(A_CTL, 8'hd0);
        repeat (10) @(posedge clk);
        rchk(A_CNT, 8'h00);
        tec_pin_source_inst.drive(1'b0, 4);
        len = 2 * (4 + $urandom % 40);
        tec_pin_source_inst.drive(1'b1, len);
        tec_pin_source_inst.drive(1'b0, 4);
        rchk(A_CTL, 8'hc0);
        rd(A_CNT, q);
        rng(q, len / 2);
        tec_pin_source_inst.drive(1'b1, 12);
        tec_pin_source_inst.drive(1'b0, 4);
        rchk(A_CNT, q);
        // pulse overflow: a 12-tick pulse wraps twice from fa
        wr(A_CTL, 8'hc0);
        wr(A_CNT, 8'hfa);
        wr(A_CTL, 8'hd0);
        tec_pin_source_inst.drive(1'b1, 24);
        tec_pin_source_inst.drive(1'b0, 4);
        rchk(A_CNT, adv(8'hfa, 8'hfa, 12, ov));
        rd(A_IRQ, q);
        chk(q & 8'h21, 8'h20);
        conclude();
    end
endmodule
